// ==== design/esr_defs.vh ====
// Purpose: constants for the exception special register block
// Assumes: bit numbers are little-endian (bit 0 = lsb); printed big-endian
//          bit n maps to lsb index 31-n
// Notes:   definitions only
`ifndef ESR_DEFS_VH
`define ESR_DEFS_VH

// ----------------------------------------------------------------------
// special register selects
// ----------------------------------------------------------------------
`define ESR_SEL_FLOAT_STATUS  14'h0007
`define ESR_SEL_BRANCH_TGT    14'h000B
`define ESR_SEL_FAULT_DATA    14'h000D
`define ESR_SEL_STACK_LOW     14'h0800
`define ESR_SEL_STACK_HIGH    14'h0802

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ESR_RST_BRANCH_TGT    32'h00000000
`define ESR_RST_FAULT_DATA    32'h00000000
`define ESR_RST_STACK_LOW     32'h00000000
`define ESR_RST_STACK_HIGH    32'hFFFFFFFF
`define ESR_RST_FLAGS         5'h00

// ----------------------------------------------------------------------
// float status flag positions (lsb index; printed bits 27..31)
// ----------------------------------------------------------------------
`define ESR_FS_INVALID        4
`define ESR_FS_DIV_ZERO       3
`define ESR_FS_OVERFLOW       2
`define ESR_FS_UNDERFLOW      1
`define ESR_FS_DENORM         0

// ----------------------------------------------------------------------
// exception cause codes and status word fields (lsb index)
// ----------------------------------------------------------------------
`define ESR_EC_INSTR_STORAGE  5'h11
`define ESR_EC_DATA_TLB_MISS  5'h12
`define ESR_EC_INSTR_TLB_MISS 5'h13
`define ESR_EC_STACK_VIOL     5'h07
`define ESR_SW_DELAY_SLOT     12
`define ESR_SW_BIT20          11
`define ESR_SW_BIT21          10

`endif

// ==== design/esr_special_regs.v ====
// Purpose: exception special registers: branch target, float status,
//          stream fault data, stack limits with checks, status word
// Assumes: pipeline events are one-cycle pulses synchronous to i_clk
// Notes:   read data and all outputs are registered (one cycle latency);
//          registers left out by the options read as their reset value;
//          a flag set in the cycle of a float status write is dropped;
//          a stack violation records its own cause unless a take wins
//
// Contract
// - instruction storage: bit 20 is zone fault, bits 21:26 read zero
// - data tlb miss: bit 21 is store; instruction tlb miss: all zero
// - branch target register exists only with exception support
// - capture delay-slot branch target while exception-in-progress clear
// - branch target 32 bits, read-only at 0x000B, resets zero
// - float status read and written at select 0x0007
// - float flags sticky; only special write clears them
// - flags at bits 27..31, reset zero, bits 0:26 reserved
// - stream exception stores offending stream data word
// - fault data 32 bits at 0x000D, resets zero
// - fault data exists only with links above zero and option one
// - stack-pointer access below low limit raises stack violation
// - stack low limit 32 bits at 0x0800, resets zero
// - stack-pointer access above high limit raises stack violation
// - stack high limit 32 bits at 0x0802, resets all ones
// - stack limits and checks exist only with stack protection on
// - cause codes 10001, 10010, 10011 for the three faults
// - delay-slot flag bit 19 set when excepting instruction in slot; a stack violation recorded by the block clears it
`include "esr_defs.vh"

module esr_special_regs #(
  parameter USE_EXCEPTIONS          = 1,
  parameter stream_link_count       = 1,
  parameter stream_exception_option = 1,
  parameter USE_STACK_PROTECTION    = 1
) (
  input  wire        i_clk,             // processor clock
  input  wire        i_rst_n,           // sync reset, active low
  input  wire        i_mfs,             // move_from_special read strobe
  input  wire        i_mts,             // move_to_special write strobe
  input  wire [13:0] i_special_sel,     // special_reg_select
  input  wire [31:0] i_mts_data,        // write data
  output reg  [31:0] o_mfs_data,        // read data, valid cycle after
  input  wire        i_branch_ds,       // delay-slot branch executes
  input  wire [31:0] i_branch_target,   // its target address
  input  wire        i_exc_in_progress, // exception_in_progress flag
  input  wire [4:0]  i_fpu_flags_set,   // flags to set (inv,dz,of,uf,do)
  input  wire        i_stream_exc,      // stream exception event
  input  wire [31:0] i_stream_data,     // stream word that caused it
  input  wire        i_exc_enable,      // exceptions enabled in state word
  input  wire        i_ls_valid,        // load/store issued
  input  wire        i_ls_base_sp,      // base_operand is stack_pointer_gpr
  input  wire [31:0] i_ls_addr,         // effective address on data bus
  input  wire        i_exc_take,        // exception being recorded
  input  wire [4:0]  i_exc_cause,       // cause code of that exception
  input  wire        i_exc_in_slot,     // excepting instr in delay slot
  input  wire        i_zone_fault,      // zone protection caused fault
  input  wire        i_tlb_store,       // tlb miss came from a store
  output reg  [12:0] o_status_word,     // status bits 19..31 (lsb=31)
  output reg         o_stack_violation  // stack violation pulse
);

  localparam HAS_BRANCH_TGT = (USE_EXCEPTIONS != 0);
  localparam HAS_FAULT_DATA = (stream_link_count > 0) &&
                              (stream_exception_option == 1);
  localparam HAS_STK = (USE_STACK_PROTECTION == 1);

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  reg [31:0] delay_branch_target_reg;
  reg [4:0]  float_status_flags_reg;
  reg [31:0] stream_fault_data_reg;
  reg [31:0] stack_low_limit_reg;
  reg [31:0] stack_high_limit_reg;
  reg [31:0] delay_branch_target_next;
  reg [31:0] stream_fault_data_next;
  reg [31:0] stack_low_limit_next;
  reg [31:0] stack_high_limit_next;
  reg [4:0]  flags_next;
  reg [31:0] rd_next;
  reg [6:0]  spec_status_next;
  reg [12:0] status_next;
  reg        viol_next;

  // ----------------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------------
  // strobe aimed at one special register
  function sel_hit;
    input        strobe;
    input [13:0] sel;
    input [13:0] code;
    begin
      sel_hit = strobe && (sel == code);
    end
  endfunction

  // unsigned 32-bit compare, a strictly below b
  function addr_lt;
    input [31:0] a;
    input [31:0] b;
    begin
      addr_lt = (a < b);
    end
  endfunction

  // one sticky flag: a write value wins, else set or hold
  function sticky;
    input cur;
    input set;
    input wr;
    input wval;
    begin
      if (wr) begin
        sticky = wval;
      end else begin
        sticky = cur | set;
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // select decode
  // ----------------------------------------------------------------------
  wire wr_fs     = sel_hit(i_mts, i_special_sel, `ESR_SEL_FLOAT_STATUS);
  wire wr_low    = sel_hit(i_mts, i_special_sel, `ESR_SEL_STACK_LOW);
  wire wr_high   = sel_hit(i_mts, i_special_sel, `ESR_SEL_STACK_HIGH);
  wire rd_flags  = sel_hit(1'b1, i_special_sel, `ESR_SEL_FLOAT_STATUS);
  wire rd_branch = sel_hit(1'b1, i_special_sel, `ESR_SEL_BRANCH_TGT);
  wire rd_fault  = sel_hit(1'b1, i_special_sel, `ESR_SEL_FAULT_DATA);
  wire rd_low    = sel_hit(1'b1, i_special_sel, `ESR_SEL_STACK_LOW);
  wire rd_high   = sel_hit(1'b1, i_special_sel, `ESR_SEL_STACK_HIGH);

  // ----------------------------------------------------------------------
  // event qualification
  // ----------------------------------------------------------------------
  // a branch inside a handler must not clobber the saved target
  wire branch_capture = HAS_BRANCH_TGT && i_branch_ds && !i_exc_in_progress;
  wire fault_capture  = HAS_FAULT_DATA && i_stream_exc;
  wire set_invalid    = i_fpu_flags_set[`ESR_FS_INVALID];
  wire set_div_zero   = i_fpu_flags_set[`ESR_FS_DIV_ZERO];
  wire set_overflow   = i_fpu_flags_set[`ESR_FS_OVERFLOW];
  wire set_underflow  = i_fpu_flags_set[`ESR_FS_UNDERFLOW];
  wire set_denorm     = i_fpu_flags_set[`ESR_FS_DENORM];

  // ----------------------------------------------------------------------
  // branch target capture
  // ----------------------------------------------------------------------
  always @* begin
    delay_branch_target_next = delay_branch_target_reg;
    if (branch_capture) begin
      delay_branch_target_next = i_branch_target;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n || !HAS_BRANCH_TGT) begin
      delay_branch_target_reg <= `ESR_RST_BRANCH_TGT;
    end else begin
      delay_branch_target_reg <= delay_branch_target_next;
    end
  end

  // ----------------------------------------------------------------------
  // float status flags
  // ----------------------------------------------------------------------
  always @* begin
    flags_next[`ESR_FS_INVALID] =
      sticky(float_status_flags_reg[`ESR_FS_INVALID], set_invalid,
             wr_fs, i_mts_data[`ESR_FS_INVALID]);
    flags_next[`ESR_FS_DIV_ZERO] =
      sticky(float_status_flags_reg[`ESR_FS_DIV_ZERO], set_div_zero,
             wr_fs, i_mts_data[`ESR_FS_DIV_ZERO]);
    flags_next[`ESR_FS_OVERFLOW] =
      sticky(float_status_flags_reg[`ESR_FS_OVERFLOW], set_overflow,
             wr_fs, i_mts_data[`ESR_FS_OVERFLOW]);
    flags_next[`ESR_FS_UNDERFLOW] =
      sticky(float_status_flags_reg[`ESR_FS_UNDERFLOW], set_underflow,
             wr_fs, i_mts_data[`ESR_FS_UNDERFLOW]);
    flags_next[`ESR_FS_DENORM] =
      sticky(float_status_flags_reg[`ESR_FS_DENORM], set_denorm,
             wr_fs, i_mts_data[`ESR_FS_DENORM]);
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      float_status_flags_reg <= `ESR_RST_FLAGS;
    end else begin
      float_status_flags_reg <= flags_next;
    end
  end

  // ----------------------------------------------------------------------
  // stream fault data
  // ----------------------------------------------------------------------
  always @* begin
    stream_fault_data_next = stream_fault_data_reg;
    if (fault_capture) begin
      stream_fault_data_next = i_stream_data;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n || !HAS_FAULT_DATA) begin
      stream_fault_data_reg <= `ESR_RST_FAULT_DATA;
    end else begin
      stream_fault_data_reg <= stream_fault_data_next;
    end
  end

  // ----------------------------------------------------------------------
  // stack limits and checks
  // ----------------------------------------------------------------------
  always @* begin
    stack_low_limit_next  = stack_low_limit_reg;
    stack_high_limit_next = stack_high_limit_reg;
    if (wr_low) begin
      stack_low_limit_next = i_mts_data;
    end
    if (wr_high) begin
      stack_high_limit_next = i_mts_data;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n || !HAS_STK) begin
      stack_low_limit_reg  <= `ESR_RST_STACK_LOW;
      stack_high_limit_reg <= `ESR_RST_STACK_HIGH;
    end else begin
      stack_low_limit_reg  <= stack_low_limit_next;
      stack_high_limit_reg <= stack_high_limit_next;
    end
  end

  // only stack-pointer based accesses with exceptions on are policed
  wire ls_sp = HAS_STK && i_ls_valid && i_ls_base_sp && i_exc_enable;
  wire below = addr_lt(i_ls_addr, stack_low_limit_reg);
  wire above = addr_lt(stack_high_limit_reg, i_ls_addr);

  always @* begin
    viol_next = 1'b0;
    if (ls_sp) begin
      viol_next = below || above;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_stack_violation <= 1'b0;
    end else begin
      o_stack_violation <= viol_next;
    end
  end

  // ----------------------------------------------------------------------
  // exception status word: delay slot, specific status, cause
  // ----------------------------------------------------------------------
  // specific status bits 20..26 sit in [6:0]; bit 20 is [6]
  always @* begin
    spec_status_next = 7'h00;
    case (i_exc_cause)
      `ESR_EC_INSTR_STORAGE: begin
        spec_status_next[6] = i_zone_fault;
      end
      `ESR_EC_DATA_TLB_MISS: begin
        spec_status_next[5] = i_tlb_store;
      end
      `ESR_EC_INSTR_TLB_MISS: begin
        spec_status_next = 7'h00;
      end
      default: begin
        spec_status_next = 7'h00;
      end
    endcase
  end

  // a take wins over a violation seen in the same cycle
  always @* begin
    status_next = o_status_word;
    if (i_exc_take) begin
      status_next[`ESR_SW_DELAY_SLOT] = i_exc_in_slot;
      status_next[11:5]               = spec_status_next;
      status_next[4:0]                = i_exc_cause;
    end else if (o_stack_violation) begin
      status_next[`ESR_SW_DELAY_SLOT] = 1'b0;
      status_next[11:5]               = 7'h00;
      status_next[4:0]                = `ESR_EC_STACK_VIOL;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_status_word <= 13'h0;
    end else begin
      o_status_word <= status_next;
    end
  end

  // ----------------------------------------------------------------------
  // move_from_special read mux
  // ----------------------------------------------------------------------
  always @* begin
    rd_next = 32'h00000000;
    // reserved float bits and unmapped selects read zero
    if (rd_flags) begin
      rd_next[4:0] = float_status_flags_reg;
    end else if (rd_branch) begin
      rd_next = delay_branch_target_reg;
    end else if (rd_fault) begin
      rd_next = stream_fault_data_reg;
    end else if (rd_low) begin
      rd_next = stack_low_limit_reg;
    end else if (rd_high) begin
      rd_next = stack_high_limit_reg;
    end else begin
      rd_next = 32'h00000000;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_mfs_data <= 32'h00000000;
    end else if (i_mfs) begin
      o_mfs_data <= rd_next;
    end
  end

endmodule // esr_special_regs

// ==== verif/esr_special_regs_monitor.sv ====
// Purpose: port checks for the special register block
// Assumes: one clock, sync active-low reset
// Notes:   bound to every esr_special_regs instance
module esr_special_regs_monitor (
  input wire logic        i_clk,             // clock
  input wire logic        i_rst_n,           // reset
  input wire logic        i_mfs,             // read strobe
  input wire logic [13:0] i_special_sel,     // select
  input wire logic        i_stream_exc,      // stream event
  input wire logic [31:0] i_stream_data,     // stream word
  input wire logic [31:0] o_mfs_data,        // read data
  input wire logic        i_ls_valid,        // load/store
  input wire logic        i_ls_base_sp,      // stack base
  input wire logic        i_exc_enable,      // enable
  input wire logic        o_stack_violation, // violation
  input wire logic        i_exc_take,        // record
  input wire logic [4:0]  i_exc_cause,       // cause
  input wire logic        i_exc_in_slot,     // in slot
  input wire logic        i_zone_fault,      // zone fault
  input wire logic        i_tlb_store,       // store miss
  input wire logic [12:0] o_status_word      // status
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic fire = i_ls_valid && i_ls_base_sp && i_exc_enable;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_take(c);
    i_exc_take && i_exc_cause == c;
  endsequence
  sequence s_fault_rd;
    i_stream_exc ##2 (i_mfs && i_special_sel == 14'h000D);
  endsequence
  chk_viol_src: assert property (
    o_stack_violation |-> $past(fire)) else $error("stray violation");
  chk_viol_quiet: assert property (
    !fire |=> !o_stack_violation) else $error("violation, no access");
  chk_viol_cause: assert property (
    o_stack_violation && !i_exc_take |=> o_status_word[4:0] == 5'h07)
    else $error("violation cause wrong");
  chk_zone_bit: assert property (
    s_take(5'h11) |=> o_status_word[11:5] == {$past(i_zone_fault), 6'h00})
    else $error("storage status wrong");
  chk_store_bit: assert property (
    s_take(5'h12) |=> o_status_word[11:5] == {1'b0, $past(i_tlb_store),
    5'h00}) else $error("data miss status wrong");
  chk_itlb_clear: assert property (
    s_take(5'h13) |=> o_status_word[11:0] == 12'h013)
    else $error("instr miss status wrong");
  chk_slot_flag: assert property (
    i_exc_take |=> o_status_word[12] == $past(i_exc_in_slot))
    else $error("slot flag wrong");
  chk_read_hold: assert property (
    !i_mfs |=> $stable(o_mfs_data)) else $error("read data moved");
  chk_fault_read: assert property (
    s_fault_rd |=> o_mfs_data == $past(i_stream_data, 3))
    else $error("fault data wrong");
endmodule // esr_special_regs_monitor

bind esr_special_regs esr_special_regs_monitor i_mon (.*);

// ==== verif/esr_pipe_model.sv ====
// Purpose: pipeline side issuing special register moves
// Assumes: requests change 1 ns after the rising edge
// Notes:   write data is inverted once released
module esr_pipe_model (
  input  wire logic        i_clk,   // clock
  input  wire logic [31:0] i_rdata, // read data
  output logic             o_mfs,   // read strobe
  output logic             o_mts,   // write strobe
  output logic [13:0]      o_sel,   // select
  output logic [31:0]      o_wdata  // write data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_mfs = 1'b0;
    o_mts = 1'b0;
    o_sel = 14'h0000;
    o_wdata = 32'h0;
  end
  task automatic wr(input logic [13:0] s, input logic [31:0] d);
    @(posedge i_clk);
    #1 o_mts = 1'b1;
    o_sel = s;
    o_wdata = d;
    @(posedge i_clk);
    #1 o_mts = 1'b0;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [13:0] s, output logic [31:0] q);
    @(posedge i_clk);
    #1 o_mfs = 1'b1;
    o_sel = s;
    @(posedge i_clk);
    #1 o_mfs = 1'b0;
    q = i_rdata;
  endtask
endmodule // esr_pipe_model

// ==== verif/tb_esr_special_regs.sv ====
// Purpose: self-checking bench for esr_special_regs
// Assumes: 200 MHz clock, inputs moved 1 ns after the edge
// Notes:   limits stay 0x100..0x200 after the table until the closing reset
module tb_esr_special_regs;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [13:0] s;
    logic        w;
    logic [31:0] d;
    logic [31:0] e;
  } esr_row_t;
  esr_row_t rows [10] = '{'{14'h0007, 1'b0, 32'h0, 32'h0},
    '{14'h000B, 1'b0, 32'h0, 32'h0}, '{14'h000D, 1'b0, 32'h0, 32'h0},
    '{14'h0800, 1'b0, 32'h0, 32'h0}, '{14'h0802, 1'b0, 32'h0, 32'hFFFFFFFF},
    '{14'h0800, 1'b1, 32'h100, 32'h100}, '{14'h0802, 1'b1, 32'h200, 32'h200},
    '{14'h000B, 1'b1, 32'h55, 32'h0}, '{14'h0007, 1'b1, 32'hFFFFFFFE, 32'h1E},
    '{14'h0003, 1'b1, 32'h1, 32'h0}};
  logic [34:0] ls [7] = '{{3'h7, 32'hFF}, {3'h3, 32'h100}, {3'h3, 32'h200},
    {3'h7, 32'h201}, {3'h7, 32'hFFFFFFFF}, {3'h1, 32'h0}, {3'h2, 32'h0}};
  logic [17:0] ec [3] = '{{13'h1811, 5'h11}, {13'h1412, 5'h12},
    {13'h1013, 5'h13}};
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_branch_ds = 1'b0;
  logic i_exc_in_progress = 1'b0, i_stream_exc = 1'b0, i_exc_enable = 1'b0;
  logic i_ls_valid = 1'b0, i_ls_base_sp = 1'b0, i_exc_take = 1'b0;
  logic i_exc_in_slot = 1'b0, i_zone_fault = 1'b0, i_tlb_store = 1'b0;
  logic [4:0] i_fpu_flags_set = 5'h00, i_exc_cause = 5'h00;
  logic [31:0] i_branch_target = 32'h0, i_stream_data = 32'h0;
  logic [31:0] i_ls_addr = 32'h0, i_mts_data, o_mfs_data, q;
  logic [13:0] i_special_sel;
  logic [12:0] o_status_word;
  logic i_mfs, i_mts, o_stack_violation;
  int errors = 0, comparisons = 0;
  esr_special_regs i_esr_special_regs (.*);
  esr_pipe_model i_esr_pipe_model (.i_clk, .i_rdata(o_mfs_data),
    .o_mfs(i_mfs), .o_mts(i_mts), .o_sel(i_special_sel), .o_wdata(i_mts_data));
  always #2.5 i_clk = ~i_clk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic stop_test;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic step;
    @(posedge i_clk);
    #1;
  endtask
  initial begin
    repeat (5000) @(posedge i_clk);
    errors++;
    stop_test;
  end
  initial begin
    repeat (4) step;
    i_rst_n = 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) i_esr_pipe_model.wr(rows[i].s, rows[i].d);
      i_esr_pipe_model.rd(rows[i].s, q);
      chk(q, rows[i].e);
    end
    step;
    i_fpu_flags_set = 5'h10;
    step;
    i_fpu_flags_set = 5'h01;
    step;
    i_fpu_flags_set = 5'h00;
    i_esr_pipe_model.rd(14'h0007, q);
    chk(q, 32'h1F);
    fork
      i_esr_pipe_model.wr(14'h0007, 32'h0);
      begin
        step;
        i_fpu_flags_set = 5'h04;
        step;
        i_fpu_flags_set = 5'h00;
      end
    join
    i_esr_pipe_model.rd(14'h0007, q);
    chk(q, 32'h0);
    step;
    i_branch_ds = 1'b1;
    i_branch_target = 32'hA5A50004;
    step;
    i_exc_in_progress = 1'b1;
    i_branch_target = 32'h00000BAD;
    step;
    i_branch_ds = 1'b0;
    i_exc_in_progress = 1'b0;
    i_esr_pipe_model.rd(14'h000B, q);
    chk(q, 32'hA5A50004);
    step;
    i_stream_exc = 1'b1;
    i_stream_data = 32'h12345678;
    step;
    i_stream_exc = 1'b0;
    i_stream_data = 32'hEDCBA987;
    i_esr_pipe_model.rd(14'h000D, q);
    chk(q, 32'h12345678);
    foreach (ls[i]) begin
      step;
      i_ls_valid = 1'b1;
      {i_ls_base_sp, i_exc_enable, i_ls_addr} = ls[i][33:0];
      step;
      i_ls_valid = 1'b0;
      chk(o_stack_violation, ls[i][34]);
      step;
      if (ls[i][34]) chk(o_status_word[4:0], 32'h7);
    end
    foreach (ec[i]) begin
      step;
      i_exc_take = 1'b1;
      i_exc_cause = ec[i][4:0];
      {i_exc_in_slot, i_zone_fault, i_tlb_store} = 3'h7;
      step;
      i_exc_take = 1'b0;
      chk(o_status_word, ec[i][17:5]);
    end
    i_rst_n = 1'b0;
    repeat (2) step;
    i_rst_n = 1'b1;
    i_esr_pipe_model.rd(14'h0802, q);
    chk(q, 32'hFFFFFFFF);
    stop_test;
  end
endmodule // tb_esr_special_regs
